// ### icu_pkg.sv
// Package: register map, field layout and encodings of the input capture channel
package icu_pkg;
  // Byte offsets on the register bus
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] BUF_OFS = 4'h4;
  localparam logic [3:0] IRQ_STAT_OFS = 4'h8;
  localparam logic [3:0] IRQ_MASK_OFS = 4'hc;
  // Control register fields
  localparam int SIDL_BIT = 13;
  localparam int TSEL_LSB = 10;
  localparam int CPI_LSB = 5;
  localparam int OVF_BIT = 4;
  localparam int BNE_BIT = 3;
  localparam int MODE_LSB = 0;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] CTRL_WMASK = 16'h3c67;
  // Interrupt status bits
  localparam int IRQ_CAP_BIT = 0;
  localparam int IRQ_OVF_BIT = 1;
  localparam int IRQ_WAKE_BIT = 2;
  localparam logic [2:0] IRQ_RESET = 3'h0;
  // Buffer
  localparam int BUF_DEPTH = 4;
  localparam int TS_WIDTH = 16;
  // Capture modes
  typedef enum logic [2:0] {
    MODE_OFF = 3'h0,
    MODE_EVERY_EDGE = 3'h1,
    MODE_FALL = 3'h2,
    MODE_RISE = 3'h3,
    MODE_PRE4 = 3'h4,
    MODE_PRE16 = 3'h5,
    MODE_DISABLED = 3'h6,
    MODE_WAKE = 3'h7
  } icu_mode_e;
  // Time base codes
  localparam logic [2:0] TSEL_TMR3 = 3'h0;
  localparam logic [2:0] TSEL_TMR2 = 3'h1;
  localparam logic [2:0] TSEL_TMR4 = 3'h2;
  localparam logic [2:0] TSEL_TMR5 = 3'h3;
  localparam logic [2:0] TSEL_TMR1 = 3'h4;
  localparam logic [2:0] TSEL_SYS = 3'h7;
endpackage : icu_pkg

// ### icu_fifo.sv
// File: four-entry capture buffer held in flip-flops
`timescale 1ns/1ps
module icu_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  input wire logic flush,
  // Write side
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [WIDTH-1:0] wr_data,
  // Read side
  input wire logic rd_pop,
  output logic rd_valid,
  output logic [WIDTH-1:0] rd_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wp_reg;
  logic [AW-1:0] rp_reg;
  logic [AW:0] cnt_reg;
  wire do_wr = wr_valid && wr_ready;
  wire do_rd = rd_pop && rd_valid;

  assign wr_ready = cnt_reg < (AW+1)'(DEPTH);
  assign rd_valid = cnt_reg != '0;
  assign rd_data = mem_reg[rp_reg];

  always_ff @(posedge clk) begin
    if (reset || flush) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (do_wr) begin
        mem_reg[wp_reg] <= wr_data;
        wp_reg <= (wp_reg == AW'(DEPTH - 1)) ? '0 : wp_reg + 1'b1;
      end
      if (do_rd) begin
        rp_reg <= (rp_reg == AW'(DEPTH - 1)) ? '0 : rp_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end
endmodule : icu_fifo

// ### icu_capture.sv
// File: input capture channel with control register, time base and Wishbone slave
//
// The Wishbone slave port and the address map were left to the implementer.
`timescale 1ns/1ps
module icu_capture #(
  parameter int DEPTH = icu_pkg::BUF_DEPTH,
  parameter int TSW = icu_pkg::TS_WIDTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  // Pin and power state
  input wire logic capture_input,
  input wire logic cpu_idle,
  input wire logic cpu_sleep,
  // Time base ticks
  input wire logic tmr1_tick,
  input wire logic tmr2_tick,
  input wire logic tmr3_tick,
  input wire logic tmr4_tick,
  input wire logic tmr5_tick,
  // Interrupts
  output logic irq
);
  // Registers
  logic [15:0] capture_control_one_reg;
  logic [2:0] irq_stat_reg;
  logic [2:0] irq_mask_reg;
  logic [TSW-1:0] counter_reg;
  logic half_reg;
  logic in_reg;
  logic [3:0] pre_reg;
  logic [1:0] cpi_cnt_reg;
  logic ovf_reg;
  logic ack_reg;
  logic [31:0] rdat_reg;

  // Control fields
  wire stop_in_idle = capture_control_one_reg[icu_pkg::SIDL_BIT];
  wire [2:0] time_base_select = capture_control_one_reg[icu_pkg::TSEL_LSB +: 3];
  wire [1:0] captures_per_interrupt = capture_control_one_reg[icu_pkg::CPI_LSB +: 2];
  icu_pkg::icu_mode_e capture_mode_select;
  assign capture_mode_select = icu_pkg::icu_mode_e'(capture_control_one_reg[icu_pkg::MODE_LSB +: 3]);

  // Mode decoding
  wire mode_off = capture_mode_select == icu_pkg::MODE_OFF;
  wire mode_dis = capture_mode_select == icu_pkg::MODE_DISABLED;
  wire mode_wake = capture_mode_select == icu_pkg::MODE_WAKE;
  wire chan_idle = mode_off || mode_dis;
  wire halted = stop_in_idle && cpu_idle;
  wire run = !chan_idle && !mode_wake && !halted;

  // Edge detection on the synchronous input
  wire rise = capture_input && !in_reg;
  wire fall = !capture_input && in_reg;

  // Time base select
  logic tb_tick;
  always_comb begin
    unique case (time_base_select)
      icu_pkg::TSEL_SYS: tb_tick = half_reg;
      icu_pkg::TSEL_TMR1: tb_tick = tmr1_tick;
      icu_pkg::TSEL_TMR2: tb_tick = tmr2_tick;
      icu_pkg::TSEL_TMR3: tb_tick = tmr3_tick;
      icu_pkg::TSEL_TMR4: tb_tick = tmr4_tick;
      icu_pkg::TSEL_TMR5: tb_tick = tmr5_tick;
      default: tb_tick = 1'b0;
    endcase
  end

  // Capture event per mode
  wire pre_wrap4 = pre_reg[1:0] == 2'h3;
  wire pre_wrap16 = pre_reg == 4'hf;
  logic cap_evt;
  always_comb begin
    unique case (capture_mode_select)
      icu_pkg::MODE_EVERY_EDGE: cap_evt = rise || fall;
      icu_pkg::MODE_FALL: cap_evt = fall;
      icu_pkg::MODE_RISE: cap_evt = rise;
      icu_pkg::MODE_PRE4: cap_evt = rise && pre_wrap4;
      icu_pkg::MODE_PRE16: cap_evt = rise && pre_wrap16;
      default: cap_evt = 1'b0;
    endcase
  end
  wire capture = run && cap_evt;

  // Buffer
  logic fifo_ready;
  logic fifo_valid;
  logic [TSW-1:0] fifo_data;
  wire wr_en = capture && fifo_ready;
  wire overflow_evt = capture && !fifo_ready;

  // Bus decode
  // Answer cycle blocks a second take of the same request
  wire bus_req = wb_cyc_i && wb_stb_i && !ack_reg && !wb_err_o;
  wire hit_ctrl = wb_adr_i == icu_pkg::CTRL_OFS;
  wire hit_buf = wb_adr_i == icu_pkg::BUF_OFS;
  wire hit_stat = wb_adr_i == icu_pkg::IRQ_STAT_OFS;
  wire hit_mask = wb_adr_i == icu_pkg::IRQ_MASK_OFS;
  wire hit_any = hit_ctrl || hit_buf || hit_stat || hit_mask;
  wire wr_ok = bus_req && wb_we_i && hit_any;
  wire rd_buf = bus_req && !wb_we_i && hit_buf;
  wire pop = rd_buf && fifo_valid;
  wire [31:0] bmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire [31:0] wdat = wb_dat_i & bmask;

  // Interrupt causes: counted captures, buffer overflow or wake edge
  wire cpi_hit = cpi_cnt_reg == captures_per_interrupt;
  wire every_edge = capture_mode_select == icu_pkg::MODE_EVERY_EDGE;
  wire cap_irq = wr_en && (every_edge || cpi_hit);
  wire wake_irq = mode_wake && (cpu_sleep || cpu_idle) && rise;
  wire [2:0] irq_set = {wake_irq, overflow_evt, cap_irq};
  wire [2:0] irq_clr = (wr_ok && hit_stat) ? wdat[2:0] : 3'h0;
  assign irq = |(irq_stat_reg & irq_mask_reg);

  // Readback
  wire [15:0] ctrl_rd = (capture_control_one_reg & icu_pkg::CTRL_WMASK)
      | (16'(ovf_reg) << icu_pkg::OVF_BIT) | (16'(fifo_valid) << icu_pkg::BNE_BIT);
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0;
    if (hit_ctrl) begin
      rd_mux = {16'h0, ctrl_rd};
    end else if (hit_buf) begin
      rd_mux = fifo_valid ? 32'(fifo_data) : 32'h0;
    end else if (hit_stat) begin
      rd_mux = {29'h0, irq_stat_reg};
    end else if (hit_mask) begin
      rd_mux = {29'h0, irq_mask_reg};
    end
  end

  wire [15:0] ctrl_next = (capture_control_one_reg & ~bmask[15:0]) | wdat[15:0];

  icu_fifo #(.WIDTH(TSW), .DEPTH(DEPTH)) u_fifo (
    .clk(clk),
    .reset(reset),
    .flush(chan_idle),
    .wr_valid(capture),
    .wr_ready(fifo_ready),
    .wr_data(counter_reg),
    .rd_pop(pop),
    .rd_valid(fifo_valid),
    .rd_data(fifo_data)
  );

  // Bus slave: one-cycle answer
  always_ff @(posedge clk) begin
    if (reset) begin
      ack_reg <= 1'b0;
      wb_err_o <= 1'b0;
      rdat_reg <= 32'h0;
    end else begin
      ack_reg <= bus_req && hit_any;
      wb_err_o <= bus_req && !hit_any;
      rdat_reg <= (bus_req && !wb_we_i) ? rd_mux : 32'h0;
    end
  end
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdat_reg;

  // Registers written by software
  always_ff @(posedge clk) begin
    if (reset) begin
      capture_control_one_reg <= icu_pkg::CTRL_RESET;
      irq_mask_reg <= icu_pkg::IRQ_RESET;
    end else if (wr_ok) begin
      if (hit_ctrl) begin
        capture_control_one_reg <= ctrl_next & icu_pkg::CTRL_WMASK;
      end
      if (hit_mask) begin
        irq_mask_reg <= (irq_mask_reg & ~bmask[2:0]) | wdat[2:0];
      end
    end
  end

  // Sticky interrupt status, set beats clear
  always_ff @(posedge clk) begin
    if (reset) begin
      irq_stat_reg <= icu_pkg::IRQ_RESET;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
    end
  end

  // Overflow flag
  always_ff @(posedge clk) begin
    if (reset || chan_idle) begin
      ovf_reg <= 1'b0;
    end else if (overflow_evt) begin
      ovf_reg <= 1'b1;
    end else if (pop) begin
      ovf_reg <= 1'b0;
    end
  end

  // Counter, prescaler and capture counting
  always_ff @(posedge clk) begin
    if (reset) begin
      counter_reg <= '0;
      half_reg <= 1'b0;
      in_reg <= 1'b0;
      pre_reg <= 4'h0;
      cpi_cnt_reg <= 2'h0;
    end else begin
      in_reg <= capture_input;
      half_reg <= !half_reg;
      if (chan_idle) begin
        counter_reg <= '0;
        pre_reg <= 4'h0;
        cpi_cnt_reg <= 2'h0;
      end else if (run) begin
        if (tb_tick) begin
          counter_reg <= counter_reg + 1'b1;
        end
        if (rise) begin
          pre_reg <= pre_reg + 4'h1;
        end
        if (wr_en && !every_edge) begin
          cpi_cnt_reg <= cpi_hit ? 2'h0 : cpi_cnt_reg + 2'h1;
        end
      end
    end
  end
endmodule : icu_capture

// ### icu_capture_asserts.sv
// Checker for the capture channel bus answers and interrupt pin
`timescale 1ns/1ps
module icu_capture_asserts (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  // Interrupt
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  endsequence
  sequence ctrl_rd_s;
    wb_ack_o && !wb_we_i && wb_adr_i == icu_pkg::CTRL_OFS;
  endsequence
  chk_req_answered: assert property (req_s |=> wb_ack_o ^ wb_err_o)
    else $error("request not answered next cycle");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_err_unmapped: assert property (req_s and wb_adr_i[1:0] != 2'h0 |=> wb_err_o && !wb_ack_o)
    else $error("unmapped access not refused");
  chk_mapped_ack: assert property (req_s and wb_adr_i[1:0] == 2'h0 |=> wb_ack_o)
    else $error("mapped access not acknowledged");
  chk_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  chk_ctrl_zeros: assert property (ctrl_rd_s |-> wb_dat_o[31:14] == 18'h0 && wb_dat_o[9:7] == 3'h0)
    else $error("unimplemented control bits set");
  chk_reset_quiet: assert property (disable iff (1'b0) reset |=> !wb_ack_o && !irq)
    else $error("outputs active after reset");
  chk_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_stb_i))
    else $error("ack without request");
endmodule : icu_capture_asserts
bind icu_capture icu_capture_asserts chk_u (.clk, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o,
  .wb_ack_o, .wb_err_o, .irq);

// ### icu_pulse_src.sv
// Pulse source standing on the mapped capture pin
`timescale 1ns/1ps
module icu_pulse_src (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Command
  input wire logic start,
  input wire logic [6:0] edges,
  // Pin
  output logic capture_input,
  output logic busy
);
  logic [6:0] left_reg;
  logic gap_reg;
  assign busy = left_reg != 7'h00;
  // Drives the routed pin, one edge per two cycles
  always_ff @(posedge clk) begin
    if (reset) begin
      left_reg <= 7'h00;
      gap_reg <= 1'b0;
      capture_input <= 1'b0;
    end else if (start && !busy) begin
      left_reg <= edges;
    end else if (busy) begin
      gap_reg <= !gap_reg;
      if (!gap_reg) begin
        capture_input <= !capture_input;
        left_reg <= left_reg - 7'h01;
      end
    end
  end
endmodule : icu_pulse_src

// ### icu_capture_bench.sv
// Testbench for the input capture channel
`timescale 1ns/1ps
`define C(a, b) begin n_checks++; if ((a) !== (b)) begin error_cnt++; $display("ERROR %0t: mismatch", $time); end end
module icu_capture_bench;
  localparam logic [3:0] CT = icu_pkg::CTRL_OFS;
  localparam logic [3:0] BF = icu_pkg::BUF_OFS;
  localparam logic [3:0] ST = icu_pkg::IRQ_STAT_OFS;
  localparam logic [3:0] MK = icu_pkg::IRQ_MASK_OFS;
  logic clk = 0, reset = 1, cyc = 0, stb = 0, we = 0, start = 0, idle = 0, sleep = 0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wd = 32'h0, q, dat_o;
  logic [6:0] edges = 7'h0;
  logic [4:0] tk = 5'h0;
  logic ack, err, ef, irq, pin, busy;
  int error_cnt = 0, n_checks = 0;
  always #2.5 clk = ~clk;
  icu_capture dut_u (.clk(clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(wd), .wb_dat_o(dat_o), .wb_ack_o(ack), .wb_err_o(err), .capture_input(pin),
    .cpu_idle(idle), .cpu_sleep(sleep), .tmr1_tick(tk[0]), .tmr2_tick(tk[1]), .tmr3_tick(tk[2]),
    .tmr4_tick(tk[3]), .tmr5_tick(tk[4]), .irq(irq));
  icu_pulse_src src_u (.clk(clk), .reset(reset), .start(start), .edges(edges), .capture_input(pin), .busy(busy));
  task automatic end_of_test;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_of_test
  task automatic fail;
    error_cnt++;
    end_of_test();
  endtask : fail
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int i;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (ack === 1'b1 || err === 1'b1) break;
    end
    if (i == 20) fail();
    q = dat_o;
    ef = err;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : bus
  function automatic logic [15:0] cv(input logic s, input logic [2:0] t, input logic [1:0] c, input logic [2:0] m);
    return {2'h0, s, t, 3'h0, c, 2'h0, m};
  endfunction : cv
  // Channel off first: flushes buffer, clears counter
  task automatic cfg(input logic [15:0] v);
    bus(1'b1, CT, 32'h0);
    bus(1'b1, ST, 32'h7);
    bus(1'b1, CT, {16'h0, v});
  endtask : cfg
  task automatic pulse(input int n);
    int i;
    edges <= 7'(n);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    @(posedge clk);
    for (i = 0; i < 200 && busy !== 1'b0; i++) @(posedge clk);
    if (i == 200) fail();
    repeat (3) @(posedge clk);
  endtask : pulse
  task automatic tick(input logic [4:0] m, input int n);
    repeat (n) begin
      tk <= m;
      @(posedge clk);
      tk <= 5'h0;
      @(posedge clk);
    end
  endtask : tick
  task automatic t_regs;
    bus(1'b0, CT, 32'h0);
    `C(q, 32'h0)
    bus(1'b1, CT, 32'hffffffff);
    bus(1'b0, CT, 32'h0);
    `C(q, 32'h3c67)
    bus(1'b0, 4'h2, 32'h0);
    `C(ef, 1'b1)
  endtask : t_regs
  task automatic t_base;
    logic [2:0] codes [5] = '{icu_pkg::TSEL_TMR1, icu_pkg::TSEL_TMR2, icu_pkg::TSEL_TMR3, icu_pkg::TSEL_TMR4,
      icu_pkg::TSEL_TMR5};
    logic [31:0] v;
    for (int i = 0; i < 5; i++) begin
      cfg(cv(1'b0, codes[i], 2'h0, icu_pkg::MODE_RISE));
      tick(5'h1 << i, 3);
      tick(~(5'h1 << i), 2);
      pulse(2);
      bus(1'b0, BF, 32'h0);
      `C(q, 32'h3)
    end
    // Half-rate base: edges two cycles apart differ by one count
    cfg(cv(1'b0, icu_pkg::TSEL_SYS, 2'h0, icu_pkg::MODE_EVERY_EDGE));
    pulse(2);
    bus(1'b0, BF, 32'h0);
    v = q;
    bus(1'b0, BF, 32'h0);
    `C(q - v, 32'h1)
    // Reserved code: counter stands still
    cfg(cv(1'b0, 3'h5, 2'h0, icu_pkg::MODE_RISE));
    tick(5'h1f, 3);
    pulse(2);
    bus(1'b0, CT, 32'h0);
    `C(q[3], 1'b1)
    bus(1'b0, BF, 32'h0);
    `C(q, 32'h0)
  endtask : t_base
  task automatic t_fill;
    cfg(cv(1'b0, icu_pkg::TSEL_TMR1, 2'h0, icu_pkg::MODE_RISE));
    for (int i = 1; i <= 5; i++) begin
      tick(5'h1, 1);
      pulse(2);
    end
    bus(1'b0, CT, 32'h0);
    `C(q[4:3], 2'h3)
    bus(1'b0, ST, 32'h0);
    `C(q[1], 1'b1)
    for (int i = 1; i <= 4; i++) begin
      bus(1'b0, BF, 32'h0);
      `C(q, 32'(i))
    end
    bus(1'b0, CT, 32'h0);
    `C(q[4:3], 2'h0)
    bus(1'b0, BF, 32'h0);
    `C(q, 32'h0)
  endtask : t_fill
  task automatic t_irq;
    bus(1'b1, MK, 32'h1);
    for (int c = 0; c < 4; c++) begin
      cfg(cv(1'b0, icu_pkg::TSEL_TMR1, c[1:0], icu_pkg::MODE_RISE));
      pulse(2 * c);
      `C(irq, 1'b0)
      pulse(2);
      `C(irq, 1'b1)
    end
    bus(1'b1, MK, 32'h0);
    `C(irq, 1'b0)
    bus(1'b1, MK, 32'h1);
    `C(irq, 1'b1)
    bus(1'b1, ST, 32'h1);
    `C(irq, 1'b0)
  endtask : t_irq
  task automatic t_edge;
    cfg(cv(1'b0, icu_pkg::TSEL_TMR1, 2'h3, icu_pkg::MODE_EVERY_EDGE));
    tick(5'h1, 1);
    pulse(1);
    bus(1'b0, ST, 32'h0);
    `C(q[0], 1'b1)
    tick(5'h1, 1);
    pulse(1);
    bus(1'b0, BF, 32'h0);
    `C(q, 32'h1)
    bus(1'b0, BF, 32'h0);
    `C(q, 32'h2)
  endtask : t_edge
  task automatic t_modes;
    logic [2:0] m [5] = '{icu_pkg::MODE_FALL, icu_pkg::MODE_PRE4, icu_pkg::MODE_PRE16, icu_pkg::MODE_OFF,
      icu_pkg::MODE_DISABLED};
    int n [5] = '{1, 6, 30, 2, 2};
    logic e [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
    for (int k = 0; k < 5; k++) begin
      cfg(cv(1'b0, icu_pkg::TSEL_TMR1, 2'h0, m[k]));
      pulse(n[k]);
      bus(1'b0, CT, 32'h0);
      `C(q[3], 1'b0)
      pulse(k == 0 ? 1 : 2);
      bus(1'b0, CT, 32'h0);
      `C(q[3], e[k])
    end
  endtask : t_modes
  task automatic t_wake;
    bus(1'b1, MK, 32'h4);
    cfg(cv(1'b0, 3'h0, 2'h0, icu_pkg::MODE_WAKE));
    pulse(2);
    `C(irq, 1'b0)
    sleep <= 1'b1;
    pulse(2);
    `C(irq, 1'b1)
    bus(1'b0, CT, 32'h0);
    `C(q[3], 1'b0)
    sleep <= 1'b0;
  endtask : t_wake
  task automatic t_idle;
    cfg(cv(1'b1, icu_pkg::TSEL_TMR1, 2'h0, icu_pkg::MODE_RISE));
    idle <= 1'b1;
    pulse(2);
    bus(1'b0, CT, 32'h0);
    `C(q[3], 1'b0)
    cfg(cv(1'b0, icu_pkg::TSEL_TMR1, 2'h0, icu_pkg::MODE_RISE));
    pulse(2);
    bus(1'b0, CT, 32'h0);
    `C(q[3], 1'b1)
    idle <= 1'b0;
  endtask : t_idle
  initial begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    t_regs();
    t_base();
    t_fill();
    t_irq();
    t_edge();
    t_modes();
    t_wake();
    t_idle();
    end_of_test();
  end
endmodule : icu_capture_bench
